// ### core/fwp_consts.svh
// Offsets, field positions and erased values of the write-lock bytes.
`ifndef FWP_CONSTS_SVH
`define FWP_CONSTS_SVH
`define FWP_OFS_LOW      24'h30000a
`define FWP_OFS_HIGH     24'h30000b
// The lock byte offsets are word indices: each byte has a word of its own.
`define FWP_ADDR_LOW     (`FWP_OFS_LOW << 2)
`define FWP_ADDR_HIGH    (`FWP_OFS_HIGH << 2)
`define FWP_OFS_CTRL     24'h300100
`define FWP_OFS_STAT     24'h300104
`define FWP_LOW_MASK     8'h0f
`define FWP_HIGH_MASK    8'he0
`define FWP_ERASED       8'hff
`define FWP_BIT_EEPROM   7
`define FWP_BIT_BOOT     6
`define FWP_BIT_CONFIG   5
`define FWP_BOOT_LAST    24'h0001ff
`define FWP_BLK0_LAST    24'h001fff
`define FWP_BLK1_LAST    24'h003fff
`define FWP_BLK2_LAST    24'h005fff
`define FWP_BLK3_LAST    24'h007fff
`define FWP_HTRANS_NSEQ  2'h2
`define FWP_HSIZE_WORD   3'h2
`endif

// ### core/fwp_pkg.sv
// Types shared by the write-lock configuration block.
package fwp_pkg;
    typedef enum logic [1:0] {
        FWP_IDLE = 2'b01,
        FWP_DATA = 2'b10
    } fwp_state_e;

    typedef struct packed {
        logic [23:0] addr;
        logic        write;
        logic        valid;
    } fwp_req_s;

    typedef struct packed {
        logic [23:0] addr;
        logic        eeprom;
        logic        config_area;
        logic        user_mode;
        logic        valid;
    } fwp_chk_s;
endpackage

// ### core/fwp_top.sv
// Write-lock configuration bytes, region checker and AHB-Lite slave.
//
// Functional notes
// - Low byte bit 3 blocks self-writes to block 3 when 0, allows at 1.
// - Block 2 spans 004000h-005FFFh, guarded by low byte bit 2.
// - Block 1 spans 002000h-003FFFh, guarded by low byte bit 1.
// - Block 0 spans 000200h-001FFFh, guarded by low byte bit 0.
// - Boot block spans 000000h-0001FFh, guarded by the boot lock bit.
// - High byte bit 7 at 0 blocks data EEPROM writes.
// - High byte bit 6 at 0 blocks boot block writes.
// - Low bits 7-4 and high bits 4-0 always read zero.
// - Implemented bits read 1 when erased and may only be cleared.
// - Bits cleared over the bus hold until a reset, which reloads nv_low and nv_high.
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
`include "fwp_consts.svh"
module fwp_top (
    // Clock and reset.
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // Nonvolatile image, sampled after reset release.
    input  wire logic [7:0]       nv_low,
    input  wire logic [7:0]       nv_high,
    // AHB-Lite slave.
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // Self-write check from the on-chip write logic.
    input  wire fwp_pkg::fwp_chk_s chk,
    output logic                  chk_allow,
    output logic                  chk_deny
);
    // ------------------------------------------------------------
    // Lock bytes
    // ------------------------------------------------------------
    // The bytes come up erased and take the nonvolatile image one cycle
    // after reset release, so a reset never disturbs programmed values.
    logic [7:0]  low_q, low_d, high_q, high_d;
    logic        loaded_q, loaded_d;
    logic        user_q, user_d;
    logic        stat_deny_q, stat_deny_d;
    logic [31:0] rdata_d;
    logic        allow_d, deny_d;
    fwp_pkg::fwp_state_e state_q, state_d;
    fwp_pkg::fwp_req_s   req_q, req_d;
    logic        region_ok;
    logic [3:0]  blk_hit;
    logic        boot_hit;

    // ------------------------------------------------------------
    // Region decode
    // ------------------------------------------------------------
    logic [23:0] blk_last [4];
    assign blk_last[0] = `FWP_BLK0_LAST;
    assign blk_last[1] = `FWP_BLK1_LAST;
    assign blk_last[2] = `FWP_BLK2_LAST;
    assign blk_last[3] = `FWP_BLK3_LAST;
    assign boot_hit = chk.addr <= `FWP_BOOT_LAST;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_blk
            if (gi == 0) begin : g_first
                assign blk_hit[gi] = !boot_hit &&
                                     chk.addr <= blk_last[gi];
            end else begin : g_rest
                assign blk_hit[gi] = chk.addr > blk_last[gi-1] &&
                                     chk.addr <= blk_last[gi];
            end
        end
    endgenerate

    always_comb begin
        region_ok = 1'b1;
        if (chk.eeprom) begin
            region_ok = high_q[`FWP_BIT_EEPROM];
        end else if (chk.config_area) begin
            region_ok = high_q[`FWP_BIT_CONFIG];
        end else if (boot_hit) begin
            region_ok = high_q[`FWP_BIT_BOOT];
        end else begin
            region_ok = ((blk_hit & low_q[3:0]) != 4'h0) ||
                        (blk_hit == 4'h0);
        end
    end

    // ------------------------------------------------------------
    // Bus slave and lock state
    // ------------------------------------------------------------
    logic take;
    logic [23:0] word_ofs;
    assign take = hsel && hready && htrans == `FWP_HTRANS_NSEQ &&
                  hsize == `FWP_HSIZE_WORD;
    assign word_ofs = req_q.addr;

    always_comb begin
        low_d       = low_q;
        high_d      = high_q;
        loaded_d    = 1'b1;
        user_d      = user_q;
        stat_deny_d = stat_deny_q;
        rdata_d     = 32'h0000_0000;
        state_d     = fwp_pkg::FWP_IDLE;
        req_d       = '0;
        allow_d     = chk.valid && region_ok;
        deny_d      = chk.valid && !region_ok;
        if (!loaded_q) begin
            low_d  = nv_low & `FWP_LOW_MASK;
            high_d = nv_high & `FWP_HIGH_MASK;
        end
        if (chk.valid && !region_ok) begin
            stat_deny_d = 1'b1;
        end
        if (take) begin
            state_d = fwp_pkg::FWP_DATA;
            req_d   = '{addr: haddr[23:0], write: hwrite, valid: 1'b1};
            if (!hwrite) begin
                case (haddr[23:0])
                    `FWP_ADDR_LOW:  rdata_d = {24'h000000, low_q};
                    `FWP_ADDR_HIGH: rdata_d = {24'h000000, high_q};
                    `FWP_OFS_CTRL:  rdata_d = {31'h0, user_q};
                    `FWP_OFS_STAT:  rdata_d = {31'h0, stat_deny_q};
                    default:        rdata_d = 32'h0000_0000;
                endcase
            end
        end
        if (state_q == fwp_pkg::FWP_DATA && req_q.write) begin
            case (word_ofs)
                `FWP_ADDR_LOW: begin
                    // Bits may only go from 1 to 0.
                    low_d = low_q & (hwdata[7:0] | ~`FWP_LOW_MASK);
                end
                `FWP_ADDR_HIGH: begin
                    high_d = high_q &
                             (hwdata[7:0] | ~`FWP_HIGH_MASK);
                    if (user_q) begin
                        high_d[`FWP_BIT_CONFIG] =
                            high_q[`FWP_BIT_CONFIG];
                    end
                end
                `FWP_OFS_CTRL: user_d = user_q | hwdata[0];
                `FWP_OFS_STAT: begin
                    if (hwdata[0]) begin
                        stat_deny_d = chk.valid && !region_ok;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_q       <= `FWP_ERASED & `FWP_LOW_MASK;
            high_q      <= `FWP_ERASED & `FWP_HIGH_MASK;
            loaded_q    <= 1'b0;
            user_q      <= 1'b0;
            stat_deny_q <= 1'b0;
            state_q     <= fwp_pkg::FWP_IDLE;
            req_q       <= '0;
        end else begin
            low_q       <= low_d;
            high_q      <= high_d;
            loaded_q    <= loaded_d;
            user_q      <= user_d;
            stat_deny_q <= stat_deny_d;
            state_q     <= state_d;
            req_q       <= req_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            chk_allow <= 1'b0;
            chk_deny  <= 1'b0;
        end else begin
            hrdata    <= rdata_d;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            chk_allow <= allow_d;
            chk_deny  <= deny_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    low_zero_a: assert property ((low_q & ~`FWP_LOW_MASK) == 8'h00)
        else $error("Unimplemented low bits nonzero.");
    high_zero_a: assert property ((high_q & ~`FWP_HIGH_MASK) == 8'h00)
        else $error("Unimplemented high bits nonzero.");
    never_set_a: assert property (
        loaded_q |=> (low_q & ~$past(low_q)) == 8'h00)
        else $error("Low lock bit went from 0 to 1.");
    hold_high_a: assert property (
        loaded_q |=> (high_q & ~$past(high_q)) == 8'h00)
        else $error("High lock bit went from 0 to 1.");
    eeprom_lock_a: assert property (
        chk.valid && chk.eeprom && !high_q[`FWP_BIT_EEPROM]
        |=> chk_deny && !chk_allow)
        else $error("EEPROM write not refused.");
    boot_lock_a: assert property (
        chk.valid && !chk.eeprom && !chk.config_area && boot_hit &&
        !high_q[`FWP_BIT_BOOT] |=> chk_deny)
        else $error("Boot block write not refused.");
    blk3_lock_a: assert property (
        chk.valid && !chk.eeprom && !chk.config_area && blk_hit[3]
        |=> chk_allow == $past(low_q[3]))
        else $error("Block 3 decision wrong.");
    blk0_lock_a: assert property (
        chk.valid && !chk.eeprom && !chk.config_area && blk_hit[0]
        |=> chk_deny == !$past(low_q[0]))
        else $error("Block 0 decision wrong.");
    user_cfg_a: assert property (
        user_q && loaded_q |=>
        high_q[`FWP_BIT_CONFIG] == $past(high_q[`FWP_BIT_CONFIG]))
        else $error("Config lock changed in user mode.");

    deny_c: cover property (chk_deny);
    allow_c: cover property (chk_allow);
    clear_c: cover property (loaded_q ##1 $fell(low_q[1]));
    user_c: cover property ($rose(user_q));
endmodule

// ### verif/fwp_top_tb.sv
// Self-checking testbench for the write-lock configuration block.
`timescale 1ns/1ps
`include "fwp_consts.svh"
module fwp_top_tb;
    localparam logic [31:0] LOW_A  = {8'h00, `FWP_ADDR_LOW};
    localparam logic [31:0] HIGH_A = {8'h00, `FWP_ADDR_HIGH};
    localparam logic [31:0] CTRL_A = {8'h00, `FWP_OFS_CTRL};
    localparam logic [31:0] STAT_A = {8'h00, `FWP_OFS_STAT};
    logic                hclk = 1'b0;
    logic                hresetn = 1'b0;
    logic [7:0]          nv_low = 8'hff;
    logic [7:0]          nv_high = 8'hff;
    logic                hsel = 1'b0;
    logic                hwrite = 1'b0;
    logic [31:0]         haddr = '0;
    logic [31:0]         hwdata = '0;
    logic [1:0]          htrans = '0;
    logic [2:0]          hsize = `FWP_HSIZE_WORD;
    fwp_pkg::fwp_chk_s   chk = '0;
    logic [31:0]         hrdata;
    logic                hreadyout;
    logic                hresp;
    logic                chk_allow;
    logic                chk_deny;
    logic [31:0]         rd;
    int                  err_total = 0;
    int                  cmp_count = 0;

    always #5 hclk = ~hclk;

    fwp_top fwp_top_i (.hclk(hclk), .hresetn(hresetn), .nv_low(nv_low),
        .nv_high(nv_high), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .chk(chk), .chk_allow(chk_allow),
        .chk_deny(chk_deny));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task cmp(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task close_out;
        $display("errors=%0d compares=%0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Holds address phase, then data phase, until hready is seen high.
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= `FWP_HTRANS_NSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        cmp({31'h0, hresp}, 32'h0);
    endtask

    task query(input logic [23:0] a, input logic e, c, x);
        @(posedge hclk);
        chk <= '{addr: a, eeprom: e, config_area: c, user_mode: 1'b0,
                 valid: 1'b1};
        @(posedge hclk);
        chk.valid <= 1'b0;
        @(posedge hclk);
        cmp({31'h0, chk_allow}, {31'h0, x});
        cmp({31'h0, chk_deny}, {31'h0, ~x});
    endtask

    task do_reset(input logic [7:0] lo, input logic [7:0] hi);
        @(posedge hclk);
        hresetn <= 1'b0;
        nv_low <= lo;
        nv_high <= hi;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_regions;
        logic [23:0] ra [10];
        logic [9:0]  rx;
        ra = '{24'h000100, 24'h0001ff, 24'h000200, 24'h001fff, 24'h002000,
               24'h003fff, 24'h004000, 24'h005fff, 24'h006000, 24'h008000};
        rx = 10'b1100110000;
        ahb(1'b0, LOW_A, 32'h0);
        cmp(rd, 32'h0000000f);
        ahb(1'b0, HIGH_A, 32'h0);
        cmp(rd, 32'h000000e0);
        ahb(1'b1, LOW_A, 32'hfffffffa);
        ahb(1'b1, HIGH_A, 32'hffffffa0);
        // Writing ones back must not set any cleared bit.
        ahb(1'b1, LOW_A, 32'hffffffff);
        ahb(1'b1, HIGH_A, 32'hffffffff);
        ahb(1'b0, LOW_A, 32'h0);
        cmp(rd, 32'h0000000a);
        ahb(1'b0, HIGH_A, 32'h0);
        cmp(rd, 32'h000000a0);
        for (int i = 0; i < 10; i++) begin
            query(ra[i], 1'b0, 1'b0, rx[i]);
        end
        query(24'h000000, 1'b1, 1'b0, 1'b1);
        query(24'h000000, 1'b0, 1'b1, 1'b1);
    endtask

    task t_user_mode;
        ahb(1'b1, CTRL_A, 32'h1);
        ahb(1'b0, CTRL_A, 32'h0);
        cmp(rd, 32'h00000001);
        // The config lock bit must survive a clear while in user mode.
        ahb(1'b1, LOW_A, 32'hfffffff7);
        ahb(1'b1, HIGH_A, 32'hffffff5f);
        ahb(1'b0, LOW_A, 32'h0);
        cmp(rd, 32'h00000002);
        ahb(1'b0, HIGH_A, 32'h0);
        cmp(rd, 32'h00000020);
        query(24'h007fff, 1'b0, 1'b0, 1'b0);
        query(24'h003000, 1'b1, 1'b0, 1'b0);
        query(24'h003000, 1'b0, 1'b1, 1'b1);
    endtask

    task t_programmed;
        do_reset(8'hf3, 8'h5f);
        ahb(1'b0, LOW_A, 32'h0);
        cmp(rd, 32'h00000003);
        ahb(1'b0, HIGH_A, 32'h0);
        cmp(rd, 32'h00000040);
        query(24'h001000, 1'b0, 1'b1, 1'b0);
        query(24'h0001ff, 1'b0, 1'b0, 1'b1);
        query(24'h004000, 1'b0, 1'b0, 1'b0);
        query(24'h003fff, 1'b0, 1'b0, 1'b1);
    endtask

    task t_unmapped;
        ahb(1'b1, 32'h00300200, 32'hffffffff);
        ahb(1'b0, 32'h00300200, 32'h0);
        cmp(rd, 32'h0);
        ahb(1'b0, LOW_A, 32'h0);
        cmp(rd, 32'h00000003);
        // Denies seen since the last reset leave the sticky flag set.
        ahb(1'b0, STAT_A, 32'h0);
        cmp(rd, 32'h00000001);
        ahb(1'b1, STAT_A, 32'h1);
        ahb(1'b0, STAT_A, 32'h0);
        cmp(rd, 32'h00000000);
        ahb(1'b0, CTRL_A, 32'h0);
        cmp(rd, 32'h00000000);
    endtask

    initial begin
        do_reset(8'hff, 8'hff);
        t_regions();
        t_user_mode();
        t_programmed();
        t_unmapped();
        close_out();
    end

    // The whole run needs well under a thousand cycles.
    initial begin
        #200000;
        err_total++;
        close_out();
    end
endmodule
